// *** oe_ctrl_pkg.sv ***
// Shared constants and carrier types for the output-enable control block.
// Assumes a single 50 MHz register clock; all pin inputs arrive asynchronously.
package oe_ctrl_pkg;

   // Output count and pin-group geometry
   localparam int NUM_OUT = 20;        // Clock output pairs
   localparam int PIN_CNT = 8;         // Enable pins, for outputs 5 through 12
   localparam int FIRST_PIN_OUT = 5;   // Output served by enable pin 0
   localparam int PIN_DATA = 0;        // Enable pin reused as serial data
   localparam int PIN_SCLK = 1;        // Enable pin reused as serial clock
   localparam int PIN_LOAD = 5;        // Enable pin reused as shift-load

   // Enable latency, in input clock cycles
   localparam int LAT_MIN_EDGES = 4;
   localparam int LAT_MAX_EDGES = 10;

   // Register map, byte addresses
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE = 8'h00;   // Per-output enable bits
   localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h04;     // Force-enable mask bits
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;   // Read-only status
   localparam logic [ADDR_W-1:0] ADDR_SHIFT = 8'h0C;    // Read-only output register

   // Reset values
   localparam logic [NUM_OUT-1:0] ENABLE_RST = 20'hf_ffff;
   localparam logic [NUM_OUT-1:0] MASK_RST = 20'h0_0000;
   localparam logic [NUM_OUT-1:0] OUTREG_RST = 20'hf_ffff;

   // Status field positions
   localparam int STAT_MODE_BIT = 0;
   localparam int STAT_STARTED_BIT = 1;
   localparam int STAT_PG_BIT = 2;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Active enable interface
   typedef enum logic {
      MODE_TRAD = 1'b0,
      MODE_SIDEBAND = 1'b1
   } mode_e;

   // Serial link pins after synchronisation
   typedef struct packed {
      logic data;
      logic sclk;
      logic load;
   } link_s;

endpackage : oe_ctrl_pkg

// *** pin_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes each bit is a level; no bus coherency across bits is promised.
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_ff; // First stage, read only by the second

   // Both stages freeze with the clock enable
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_ff <= '0;
         sync_out <= '0;
      end
      else if (clk_en)
      begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule : pin_sync

// *** enable_gate.sv ***
// One output's enable gate: applies a new request only at an input clock low
// phase, after a fixed count of input clock cycles. Assumes fall pulses are
// already synchronised to aclk.
`timescale 1ns/10ps
module enable_gate #(
   parameter int LAT = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic in_clk_fall,
   input wire logic req,
   output logic gate_ff
);

   logic [3:0] cnt_ff; // Input clock falls seen since the request differed

   // Change only on a fall so the output never sees a runt pulse
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_ff <= 4'h0;
         gate_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         if (req == gate_ff)
            cnt_ff <= 4'h0; // Request withdrawn or met, restart
         else if (in_clk_fall)
         begin
            if (cnt_ff == 4'(LAT - 1))
            begin
               gate_ff <= req;
               cnt_ff <= 4'h0;
            end
            else
               cnt_ff <= cnt_ff + 4'h1;
         end
      end
   end

   property p_gate_hold;
      @(posedge aclk) disable iff (!aresetn)
      (clk_en && req != gate_ff && cnt_ff < 4'(LAT - 1)) |=> $stable(gate_ff);
   endproperty
   a_gate_hold: assert property (p_gate_hold)
      else $error("gate changed before the latency count");

   property p_gate_only_on_fall;
      @(posedge aclk) disable iff (!aresetn)
      $changed(gate_ff) |-> $past(in_clk_fall);
   endproperty
   a_gate_only_on_fall: assert property (p_gate_only_on_fall)
      else $error("gate changed outside an input clock fall");

endmodule : enable_gate

// *** output_enable_sideband_control.sv ***
// Output-enable control for a 20-output clock fan-out buffer, with an
// AXI4-Lite register slave. Assumes all pins are asynchronous to aclk and
// that the input clock runs well below half of aclk.
`timescale 1ns/10ps

// Notes on behaviour
// - Pins for outputs 5-12, enable bit per output
// - Load high: serial clock rise shifts data
// - Load fall copies shift into output register
// - Both paths share glitch-free enable gating
// - Strap selects serial or traditional interface
// - Serial mode: pins 5,6,10 carry link
// - Serial mode: mask bit one forces its output enabled
// - Read-only status reports selected interface
// - Serial link works during power-down
// - Mask registers locked while power-good low
// - Output register and enable bits reset enabled
// - Mask bits reset to zero
// - Load low: link activity ignored
// - Serial mode: power-good low forces outputs off
// - Enable changes land within 4-10 input clocks
// - Traditional: enabled when bit one, pin low
// - First power-good high starts, later lows power down
// - New serial configuration lands within 4-10 clocks
module output_enable_sideband_control
   import oe_ctrl_pkg::*;
#(
   parameter int LAT_EDGES = 4,
   parameter bit MSB_FIRST = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic sideband_select,
   input wire logic power_good_pd_n,
   input wire logic [oe_ctrl_pkg::PIN_CNT-1:0] output_enable_pin_n,
   input wire logic input_clock_pair,
   output logic [oe_ctrl_pkg::NUM_OUT-1:0] clock_output_pair,
   input wire logic [oe_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [oe_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import oe_ctrl_pkg::*;

   // Latency must sit inside the documented window
   if (LAT_EDGES < LAT_MIN_EDGES || LAT_EDGES > LAT_MAX_EDGES)
   begin : g_bad_lat
      $error("LAT_EDGES outside the allowed latency window");
   end

   localparam int SYNC_W = PIN_CNT + 3;

   logic [SYNC_W-1:0] pins_sync;         // All pins after two flops
   logic [PIN_CNT-1:0] oe_pin_n;         // Enable pins, synchronised
   logic strap_sync;                     // Interface strap, synchronised
   logic pg_sync;                        // Power-good level, synchronised
   logic in_clk_sync;                    // Input clock level, synchronised
   logic in_clk_d_ff;                    // Input clock one sample back
   logic in_clk_fall;                    // Input clock falling edge
   link_s link_cur;                      // Link pins, this sample
   link_s link_prev_ff;                  // Link pins, previous sample
   logic sclk_rise;                      // Serial clock rising edge
   logic load_fall;                      // Shift-load falling edge
   logic started_ff;                     // First power-good high seen
   mode_e mode_ff;                       // Strap latched at start-up
   mode_e mode;                          // Interface in force
   logic [NUM_OUT-1:0] shift_ff;         // Serial shift register
   logic [NUM_OUT-1:0] out_reg_ff;       // Serial output register
   logic [NUM_OUT-1:0] enable_bits_ff;   // Software enable bits
   logic [NUM_OUT-1:0] force_enable_bit_ff; // Software force-enable mask
   logic [NUM_OUT-1:0] req;              // Requested enables
   logic [NUM_OUT-1:0] gate;             // Enables after gating
   logic aw_got_ff;                      // Write address held
   logic w_got_ff;                       // Write data held
   logic [ADDR_W-1:0] aw_addr_ff;        // Held write address
   logic [31:0] w_data_ff;               // Held write data
   logic [3:0] w_strb_ff;                // Held byte enables

   // One synchroniser for every asynchronous pin
   pin_sync #(
      .W(SYNC_W)
   ) u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .async_in({sideband_select, power_good_pd_n, input_clock_pair, output_enable_pin_n}),
      .sync_out(pins_sync)
   );

   assign {strap_sync, pg_sync, in_clk_sync, oe_pin_n} = pins_sync;

   // Pins 5, 6 and 10 double as data, clock and shift-load
   assign link_cur = '{data: oe_pin_n[PIN_DATA], sclk: oe_pin_n[PIN_SCLK],
                       load: oe_pin_n[PIN_LOAD]};
   assign sclk_rise = link_cur.sclk && !link_prev_ff.sclk;
   assign load_fall = !link_cur.load && link_prev_ff.load;
   assign in_clk_fall = !in_clk_sync && in_clk_d_ff;

   // Edge history for the link and the input clock
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         link_prev_ff <= '0;
         in_clk_d_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         link_prev_ff <= link_cur;
         in_clk_d_ff <= in_clk_sync;
      end
   end

   // Strap is caught at the first power-good high, never at reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         started_ff <= 1'b0;
         mode_ff <= MODE_TRAD;
      end
      else if (clk_en && pg_sync && !started_ff)
      begin
         started_ff <= 1'b1;
         mode_ff <= mode_e'(strap_sync);
      end
   end

   // Before start-up the live strap rules, so the link can preload
   assign mode = started_ff ? mode_ff : mode_e'(strap_sync);

   // Shift on serial clock rise while load is high; data taken from the
   // sample before the edge, since hold after the edge is very short
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         shift_ff <= '0;
      else if (clk_en && mode == MODE_SIDEBAND && link_cur.load && sclk_rise)
      begin
         if (MSB_FIRST)
            shift_ff <= {shift_ff[NUM_OUT-2:0], link_prev_ff.data};
         else
            shift_ff <= {link_prev_ff.data, shift_ff[NUM_OUT-1:1]};
      end
   end

   // Whole-register copy on the load fall; works regardless of power-good
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         out_reg_ff <= OUTREG_RST;
      else if (clk_en && mode == MODE_SIDEBAND && load_fall)
         out_reg_ff <= shift_ff;
   end

   // Requested enable per output
   always_comb
   begin
      req = '0;
      if (!pg_sync)
         req = '0;
      else if (mode == MODE_SIDEBAND)
         req = force_enable_bit_ff | out_reg_ff;
      else
      begin
         req = enable_bits_ff;
         for (int i = 0; i < PIN_CNT; i++)
            req[FIRST_PIN_OUT + i] = enable_bits_ff[FIRST_PIN_OUT + i] && !oe_pin_n[i];
      end
   end

   // One gate per output, both paths through the same logic
   for (genvar g = 0; g < NUM_OUT; g++)
   begin : g_gate
      enable_gate #(
         .LAT(LAT_EDGES)
      ) u_gate (
         .aclk(aclk),
         .aresetn(aresetn),
         .clk_en(clk_en),
         .in_clk_fall(in_clk_fall),
         .req(req[g]),
         .gate_ff(gate[g])
      );
   end

   // Outputs follow the input clock; power-good low cuts them at once
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         clock_output_pair <= '0;
      else if (clk_en)
         clock_output_pair <= (pg_sync && in_clk_sync) ? gate : '0;
   end

   // Byte-lane merge for a register write
   function automatic logic [NUM_OUT-1:0] merge(input logic [NUM_OUT-1:0] old_v,
                                                input logic [31:0] data,
                                                input logic [3:0] strb);
      logic [31:0] res;
      res = {12'h000, old_v};
      for (int b = 0; b < 4; b++)
         if (strb[b])
            res[b*8 +: 8] = data[b*8 +: 8];
      return res[NUM_OUT-1:0];
   endfunction : merge

   // Address and data channels, taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         aw_addr_ff <= '0;
         w_data_ff <= '0;
         w_strb_ff <= '0;
      end
      else if (clk_en)
      begin
         // Ready pulses for one cycle, only when its own channel holds nothing and no response waits
         s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_got_ff && !s_axi_bvalid;
         s_axi_wready <= !s_axi_wready && s_axi_wvalid && !w_got_ff && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         else if (aw_got_ff && w_got_ff)
            aw_got_ff <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         else if (aw_got_ff && w_got_ff)
            w_got_ff <= 1'b0;
      end
   end

   // Register write and its response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         enable_bits_ff <= ENABLE_RST;
         force_enable_bit_ff <= MASK_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (aw_got_ff && w_got_ff)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
            if (aw_addr_ff == ADDR_ENABLE)
               enable_bits_ff <= merge(enable_bits_ff, w_data_ff, w_strb_ff);
            else if (aw_addr_ff == ADDR_MASK && pg_sync)
               force_enable_bit_ff <= merge(force_enable_bit_ff, w_data_ff, w_strb_ff);
            else
               s_axi_bresp <= RESP_SLVERR; // Locked mask, read-only or unmapped
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Register read
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
            if (s_axi_araddr == ADDR_ENABLE)
               s_axi_rdata <= {12'h000, enable_bits_ff};
            else if (s_axi_araddr == ADDR_MASK && pg_sync)
               s_axi_rdata <= {12'h000, force_enable_bit_ff};
            else if (s_axi_araddr == ADDR_STATUS)
            begin
               s_axi_rdata[STAT_MODE_BIT] <= mode;
               s_axi_rdata[STAT_STARTED_BIT] <= started_ff;
               s_axi_rdata[STAT_PG_BIT] <= pg_sync;
            end
            else if (s_axi_araddr == ADDR_SHIFT)
               s_axi_rdata <= {12'h000, out_reg_ff};
            else
               s_axi_rresp <= RESP_SLVERR; // Locked mask or unmapped
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_load_copy;
      (clk_en && mode == MODE_SIDEBAND && load_fall) |=> out_reg_ff == $past(shift_ff);
   endproperty
   a_load_copy: assert property (p_load_copy)
      else $error("output register missed the load copy");

   property p_shift_in;
      (clk_en && mode == MODE_SIDEBAND && link_cur.load && sclk_rise && MSB_FIRST)
         |=> shift_ff == {$past(shift_ff[NUM_OUT-2:0]), $past(link_prev_ff.data)};
   endproperty
   a_shift_in: assert property (p_shift_in)
      else $error("shift register did not take the data bit");

   property p_load_low_ignored;
      (!link_cur.load) |=> $stable(shift_ff);
   endproperty
   a_load_low_ignored: assert property (p_load_low_ignored)
      else $error("shift register moved while load was low");

   property p_pg_low_off;
      (clk_en && !pg_sync) |=> clock_output_pair == '0;
   endproperty
   a_pg_low_off: assert property (p_pg_low_off)
      else $error("outputs active while power-good low");

   property p_mask_locked;
      (clk_en && aw_got_ff && w_got_ff && aw_addr_ff == ADDR_MASK && !pg_sync)
         |=> $stable(force_enable_bit_ff) && s_axi_bresp == RESP_SLVERR;
   endproperty
   a_mask_locked: assert property (p_mask_locked)
      else $error("mask written while power-good low");

   property p_reset_values;
      $rose(aresetn) |-> enable_bits_ff == ENABLE_RST && force_enable_bit_ff == MASK_RST
         && out_reg_ff == OUTREG_RST;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("wrong register values after reset");

   property p_status_mode;
      (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATUS)
         |=> s_axi_rvalid && s_axi_rdata[STAT_MODE_BIT] == $past(mode);
   endproperty
   a_status_mode: assert property (p_status_mode)
      else $error("status did not report the interface in force");

   property p_force_enable;
      (pg_sync && mode == MODE_SIDEBAND) |-> req == (force_enable_bit_ff | out_reg_ff);
   endproperty
   a_force_enable: assert property (p_force_enable)
      else $error("serial-mode request ignores the mask");

   property p_trad_pins;
      (pg_sync && mode == MODE_TRAD && oe_pin_n[0]) |-> !req[FIRST_PIN_OUT];
   endproperty
   a_trad_pins: assert property (p_trad_pins)
      else $error("traditional output enabled with its pin high");

   c_load_commit: cover property (mode == MODE_SIDEBAND && load_fall);
   c_mask_write: cover property (aw_got_ff && w_got_ff && aw_addr_ff == ADDR_MASK && pg_sync);
   c_output_on: cover property ($rose(gate[FIRST_PIN_OUT]));
   c_trad_mode: cover property (started_ff && mode == MODE_TRAD && pg_sync);

endmodule : output_enable_sideband_control

// *** sideband_host.sv ***
// Host model driving the three-wire serial enable link.
// Assumes the bench calls its tasks; the link clock parks low between frames.
`timescale 1ns/10ps
module sideband_host (
   output logic link_data,
   output logic link_sclk,
   output logic shift_load_n
);
   localparam int HALF = 80; // 160 ns link period, below the ceiling

   // Idle: load low, clock parked, data at its pull-down level
   initial
   begin
      link_data = 1'b0;
      link_sclk = 1'b0;
      shift_load_n = 1'b0;
   end

   // One update: load high, twenty rises, clock parked low, then load falls
   task automatic send_frame(input logic [19:0] bits);
      int i;
      shift_load_n = 1'b1;
      #HALF;
      for (i = 19; i >= 0; i--) // Always twenty bits, first lands highest
      begin
         link_data = bits[i];
         #HALF;
         link_sclk = 1'b1;
         #HALF;
         link_sclk = 1'b0;
      end
      #HALF;
      shift_load_n = 1'b0;
      #HALF;
      link_data = 1'b0; // Released line falls to its pull-down
   endtask : send_frame

   // Traffic meant for another device sharing clock and data
   task automatic foreign_traffic();
      int i;
      for (i = 0; i < 8; i++)
      begin
         link_data = i[0];
         #HALF;
         link_sclk = 1'b1;
         #HALF;
         link_sclk = 1'b0;
      end
      link_data = 1'b0;
   endtask : foreign_traffic
endmodule : sideband_host

// *** testbench.sv ***
// Self-checking bench for the output-enable control block.
// Assumes AXI4-Lite register access and the serial host model beside it.
`timescale 1ns/10ps
module testbench;
   import oe_ctrl_pkg::*;
   logic aclk, aresetn, sideband_select, power_good_pd_n, input_clock_pair;
   logic [7:0] pin_n_tb; // Enable pins as the bench drives them
   logic [NUM_OUT-1:0] clock_output_pair;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   logic [3:0] wstrb; // Byte enables for register writes
   logic clk_en; // Clock enable, dropped once to prove the freeze
   logic link_data, link_sclk, shift_load_n; // Host model pins
   wire logic [7:0] pins;
   int fail_count, checks_done;

   // Serial mode borrows pins 0, 1 and 5; the rest stay with the bench
   assign pins = sideband_select ?
      {pin_n_tb[7:6], shift_load_n, pin_n_tb[4:2], link_sclk, link_data} : pin_n_tb;

   sideband_host host (.link_data(link_data), .link_sclk(link_sclk),
      .shift_load_n(shift_load_n));

   output_enable_sideband_control #(.LAT_EDGES(4), .MSB_FIRST(1'b1)) uut (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .sideband_select(sideband_select),
      .power_good_pd_n(power_good_pd_n), .output_enable_pin_n(pins),
      .input_clock_pair(input_clock_pair), .clock_output_pair(clock_output_pair),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // Register clock, 20 ns
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // Input clock, 200 ns, phase unrelated to aclk
   initial
   begin
      input_clock_pair = 1'b0;
      #3;
      forever #100 input_clock_pair = ~input_clock_pair;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Address and data offered together, each released once taken
   task automatic wr_chk(input logic [7:0] addr, input logic [31:0] d, input logic [1:0] eresp);
      @(posedge aclk);
      awaddr <= addr;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      check("write resp", {30'h0000_0000, bresp}, {30'h0000_0000, eresp});
   endtask : wr_chk

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic [1:0] eresp);
      @(posedge aclk);
      araddr <= addr;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      check("read resp", {30'h0000_0000, rresp}, {30'h0000_0000, eresp});
      if (eresp === RESP_OKAY)
         check("read data", rdata, exp);
   endtask : rd_chk

   // Wait ten input clocks plus sync slack, then see which outputs toggle
   task automatic watch(input logic [NUM_OUT-1:0] exp);
      logic [NUM_OUT-1:0] seen;
      seen = '0;
      repeat (110) @(posedge aclk);
      repeat (40)
      begin
         @(posedge aclk);
         seen = seen | clock_output_pair;
      end
      check("outputs", {12'h000, seen}, {12'h000, exp});
   endtask : watch

   // Hang guard, well beyond the expected run
   initial
   begin
      #400000;
      fail_count++;
      final_report();
   end

   initial
   begin
      aresetn = 1'b0;
      clk_en = 1'b1;
      wstrb = 4'hf;
      sideband_select = 1'b1;
      power_good_pd_n = 1'b0;
      pin_n_tb = 8'hff;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      fail_count = 0;
      checks_done = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      // Serial strap, still powered down
      rd_chk(ADDR_ENABLE, 32'h000f_ffff, RESP_OKAY);
      rd_chk(ADDR_SHIFT, 32'h000f_ffff, RESP_OKAY);
      rd_chk(ADDR_STATUS, 32'h0000_0001, RESP_OKAY);
      rd_chk(ADDR_MASK, 32'h0000_0000, RESP_SLVERR);
      rd_chk(8'h10, 32'h0000_0000, RESP_SLVERR);
      #7;
      host.send_frame(20'h5_a3c1);
      rd_chk(ADDR_SHIFT, 32'h0005_a3c1, RESP_OKAY);
      watch(20'h0_0000);
      @(posedge aclk);
      power_good_pd_n <= 1'b1;
      pin_n_tb <= 8'hff; // Spare pins say disable; serial mode must ignore them
      repeat (4) @(posedge aclk); // Two sync flops plus the start-up latch
      rd_chk(ADDR_STATUS, 32'h0000_0007, RESP_OKAY);
      rd_chk(ADDR_MASK, 32'h0000_0000, RESP_OKAY);
      watch(20'h5_a3c1);
      wr_chk(ADDR_MASK, 32'h0000_0002, RESP_OKAY);
      watch(20'h5_a3c3);
      host.foreign_traffic();
      rd_chk(ADDR_SHIFT, 32'h0005_a3c1, RESP_OKAY);
      host.send_frame(20'h0_0000);
      watch(20'h0_0002);
      // Frozen block must lose a whole frame
      @(posedge aclk);
      clk_en <= 1'b0;
      #7;
      host.send_frame(20'hf_ffff);
      @(posedge aclk);
      clk_en <= 1'b1;
      rd_chk(ADDR_SHIFT, 32'h0000_0000, RESP_OKAY);
      wr_chk(ADDR_STATUS, 32'h0000_0000, RESP_SLVERR);
      // Traditional strap after a fresh reset
      @(posedge aclk);
      aresetn <= 1'b0;
      sideband_select <= 1'b0;
      power_good_pd_n <= 1'b0;
      pin_n_tb <= 8'hff;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      wr_chk(ADDR_MASK, 32'h000f_ffff, RESP_SLVERR);
      @(posedge aclk);
      power_good_pd_n <= 1'b1;
      repeat (4) @(posedge aclk); // Two sync flops plus the start-up latch
      rd_chk(ADDR_STATUS, 32'h0000_0006, RESP_OKAY);
      watch(20'hf_e01f);
      @(posedge aclk);
      pin_n_tb <= 8'h00;
      watch(20'hf_ffff);
      // Low two bytes only, then the top byte only
      wstrb <= 4'h3;
      wr_chk(ADDR_ENABLE, 32'h0005_aaaa, RESP_OKAY);
      rd_chk(ADDR_ENABLE, 32'h000f_aaaa, RESP_OKAY);
      wstrb <= 4'h4;
      wr_chk(ADDR_ENABLE, 32'h000a_5555, RESP_OKAY);
      wstrb <= 4'hf;
      @(posedge aclk);
      pin_n_tb <= 8'h0f;
      wr_chk(ADDR_MASK, 32'h000f_ffff, RESP_OKAY);
      watch(20'ha_aa0a);
      @(posedge aclk);
      power_good_pd_n <= 1'b0;
      watch(20'h0_0000);
      @(posedge aclk);
      power_good_pd_n <= 1'b1;
      watch(20'ha_aa0a);
      final_report();
   end
endmodule : testbench
